// ---- sfp_defs.svh ----
// Constants for the supply fault protection controller
`ifndef SFP_DEFS_SVH
`define SFP_DEFS_SVH

// Clock rate in kHz (40 MHz reference)
`define SFP_CLK_KHZ 40000
// Overload on window in ms
`define SFP_ON_MS 90
// Overload off window in ms
`define SFP_OFF_MS 900
// Derived cycle counts
`define SFP_ON_CYC (`SFP_ON_MS * `SFP_CLK_KHZ)
`define SFP_OFF_CYC (`SFP_OFF_MS * `SFP_CLK_KHZ)
// Internal tone carrier in Hz
`define SFP_TONE_HZ 22000
// Half period of the carrier in cycles, rounded down
`define SFP_TONE_HALF (`SFP_CLK_KHZ * 1000 / (2 * `SFP_TONE_HZ))
// Width of the output-level select field
`define SFP_LVL_W 4
// Reset value of the output-level field
`define SFP_LVL_RST 4'h0
// Window counter width
`define SFP_CNT_W 26
// Tone divider counter width
`define SFP_TDIV_W 10

`endif

// ---- sfp_pkg.sv ----
// Types for the supply fault protection controller
package sfp_pkg;
  // Overload limiter states
  typedef enum logic [1:0] {
    SFP_NORMAL,
    SFP_ON_WIN,
    SFP_OFF_WIN
  } sfp_ol_state_t;
endpackage

// ---- sfp_flag.sv ----
// Sticky diagnostic flag cleared by a status read once its cause is gone
`timescale 1ns/100ps
module sfp_flag (
  input wire logic ref_clk_i, // 40 MHz clock
  input wire logic rst_i,     // Async reset, active high
  input wire logic set_i,     // Event that sets the flag
  input wire logic cause_i,   // Underlying condition still active
  input wire logic read_i,    // Status read strobe
  output logic flag_o         // Latched flag
);
  logic flag;
  logic next_flag;

  // Set wins over a read clear; read only clears an inactive cause
  assign next_flag = set_i | (flag & ~(read_i & ~cause_i));
  assign flag_o = flag;

  // Flag storage
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end
endmodule

// ---- sfp_ctrl.sv ----
// Fault protection, recovery policy and tone gating for the LNB supply
`timescale 1ns/100ps
`include "sfp_defs.svh"
// How it works
// - Low supply sets flag, drives fault low
// - Select bit one is clamp, zero pulsed
// - Pulsed: 90 ms on, then 900 ms off
// - Overload flag set entering off window
// - Repeat off/on while overload persists
// - Clean on window resumes; flag clears on read
// - Clamp mode flags overload; read clears later
// - Restart bit one clears levels after overload
// - Restart bit zero re-enables output automatically
// - Over-temperature shuts converter, sets flag
// - Thermal restart one clears levels afterwards
// - Thermal restart zero re-enables automatically
// - Envelope mode gates internal 22 kHz carrier
// - External mode passes external tone through
// - Address pin picks one of two addresses
// - Flags latch until cause gone and read
// - Undervoltage ignores writes, zeroes data bits
// - No failure means all flags zero
module sfp_ctrl import sfp_pkg::*; #(
  parameter int ON_CYCLES = `SFP_ON_CYC,   // On window length in cycles
  parameter int OFF_CYCLES = `SFP_OFF_CYC, // Off window length in cycles
  parameter int TONE_HALF = `SFP_TONE_HALF // Carrier half period in cycles
) (
  input wire logic ref_clk_i,                   // 40 MHz clock
  input wire logic rst_i,                       // Async reset, active high
  input wire logic uvlo_i,                      // Supply below lockout
  input wire logic low_supply_i,                // Supply below low threshold
  input wire logic overload_i,                  // Current limit reached
  input wire logic overtemp_i,                  // Junction too hot
  input wire logic wr_i,                        // Host write strobe
  input wire logic [`SFP_LVL_W-1:0] lvl_wdata_i, // Written output level
  input wire logic pls_wdata_i,                 // Written pulsed-limit select
  input wire logic olr_wdata_i,                 // Written overload restart
  input wire logic thr_wdata_i,                 // Written thermal restart
  input wire logic ext_wdata_i,                 // Written external tone mode
  input wire logic ton_wdata_i,                 // Written tone on
  input wire logic status_rd_i,                 // Status read strobe
  input wire logic tone_gate_in_i,              // Tone gate pin
  input wire logic addr_sel_i,                  // Address select pin level
  output logic [`SFP_LVL_W-1:0] output_level_select_o, // Level field
  output logic pulsed_limit_select_o,           // Clamp (1) or pulsed (0)
  output logic overload_restart_mode_o,         // Overload restart policy
  output logic thermal_restart_mode_o,          // Thermal restart policy
  output logic external_tone_mode_o,            // Tone gate is a carrier
  output logic tone_on_o,                       // Tone enable bit
  output logic supply_low_flag_o,               // Latched low-supply flag
  output logic overload_flag_o,                 // Latched overload flag
  output logic overtemp_flag_o,                 // Latched over-temp flag
  output logic fault_out_n_o,                   // Fault pin, active low
  output logic power_en_o,                      // Converter and regulator on
  output logic tone_o,                          // Tone to output stage
  output logic addr_sel_o                       // Selected address, 1 = alt
);
  localparam logic [`SFP_CNT_W-1:0] ON_LAST = `SFP_CNT_W'(ON_CYCLES - 1);
  localparam logic [`SFP_CNT_W-1:0] OFF_LAST = `SFP_CNT_W'(OFF_CYCLES - 1);
  localparam logic [`SFP_TDIV_W-1:0] TONE_LAST = `SFP_TDIV_W'(TONE_HALF - 1);

  // Control bits written by the host
  logic [`SFP_LVL_W-1:0] lvl; // Output level field, zero means off
  logic pls; // Pulsed-limit select, one is clamp
  logic overload_restart_mode; // Overload restart policy
  logic thr; // Thermal restart policy
  logic ext; // Tone gate carries an external carrier
  logic ton; // Tone enable bit
  // Overload limiter
  sfp_ol_state_t ol_state;
  sfp_ol_state_t next_ol_state;
  logic [`SFP_CNT_W-1:0] win_cnt;
  logic [`SFP_CNT_W-1:0] next_win_cnt;
  logic ol_seen;     // Overload seen in current on window
  logic next_ol_seen;
  logic ol_prev;     // Overload condition last cycle
  logic ot_prev;     // Over-temp condition last cycle
  // Carrier generator
  logic [`SFP_TDIV_W-1:0] tdiv; // Half-period divider
  logic carrier; // Free-running internal carrier
  // Registered outputs
  logic tone; // Tone to output stage
  logic addr_sel; // Captured address pin
  logic power_en; // Converter and regulator enable

  // Decode wires
  wire on_done = (win_cnt == ON_LAST);
  wire off_done = (win_cnt == OFF_LAST);
  wire pulsed_mode = ~pls;
  wire in_off = pulsed_mode & (ol_state == SFP_OFF_WIN);
  // Condition behind the overload flag in either mode
  wire ol_cause = overload_i | (ol_state != SFP_NORMAL);
  wire ol_off_entry = (ol_state == SFP_ON_WIN) & on_done & (ol_seen | overload_i);
  wire ol_set = pulsed_mode ? ol_off_entry : overload_i;
  wire ol_removed = ol_prev & ~ol_cause & overload_restart_mode;
  wire ot_removed = ot_prev & ~overtemp_i & thr;
  // Either recovery under restart one empties the level field
  wire lvl_wipe = ol_removed | ot_removed;
  wire ext_gate = tone_gate_in_i;
  wire env_gate = tone_gate_in_i & carrier;
  wire tone_gate_ok = ext ? ext_gate : env_gate;
  // Tone only while powered; a dead output cannot carry it
  wire next_tone = ton & power_en & tone_gate_ok;
  // Status reads are ignored under lockout, like every other command
  wire rd_ok = status_rd_i & ~uvlo_i;
  // overload gone under restart zero, power returns by itself
  // heat gone under thermal restart zero, power returns by itself
  // The wipe cycle is masked so restart one never flashes the output on
  wire next_power_en = ~uvlo_i & ~overtemp_i & ~in_off & ~lvl_wipe &
                       (lvl != `SFP_LVL_RST);

  // Overload limiter next state
  always_comb begin
    next_ol_state = ol_state;
    next_win_cnt = win_cnt + `SFP_CNT_W'(1);
    next_ol_seen = ol_seen | overload_i;
    unique case (ol_state)
      SFP_NORMAL: begin
        next_win_cnt = '0;
        next_ol_seen = 1'b0;
        if (pulsed_mode & overload_i) begin
          next_ol_state = SFP_ON_WIN;
        end
      end
      SFP_ON_WIN: begin
        if (on_done) begin
          next_win_cnt = '0;
          next_ol_seen = 1'b0;
          if (ol_seen | overload_i) begin
            next_ol_state = SFP_OFF_WIN;
          end else begin
            next_ol_state = SFP_NORMAL;
          end
        end
      end
      SFP_OFF_WIN: begin
        next_ol_seen = 1'b0;
        if (off_done) begin
          next_win_cnt = '0;
          next_ol_state = SFP_ON_WIN;
        end
      end
      default: begin
        // Unused code: fall back to normal rather than lock up
        next_ol_state = SFP_NORMAL;
        next_win_cnt = '0;
      end
    endcase
    // Leaving pulsed mode aborts the cycle
    if (~pulsed_mode) begin
      next_ol_state = SFP_NORMAL;
      next_win_cnt = '0;
      next_ol_seen = 1'b0;
    end
  end

  // window counter on reference clock
  // One shared counter serves both windows, sized for the longer one
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ol_state <= SFP_NORMAL;
      win_cnt <= '0;
      ol_seen <= 1'b0;
    end else begin
      ol_state <= next_ol_state;
      win_cnt <= next_win_cnt;
      ol_seen <= next_ol_seen;
    end
  end

  // Cause history for recovery edge detection
  // Idle level is zero, matching reset, so no false recovery follows reset
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ol_prev <= 1'b0;
      ot_prev <= 1'b0;
    end else begin
      ol_prev <= ol_cause;
      ot_prev <= overtemp_i;
    end
  end

  // Host control bits; lockout holds them zero and drops writes
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lvl <= `SFP_LVL_RST;
      pls <= 1'b0;
      overload_restart_mode <= 1'b0;
      thr <= 1'b0;
      ext <= 1'b0;
      ton <= 1'b0;
    end else if (uvlo_i) begin
      lvl <= `SFP_LVL_RST;
      pls <= 1'b0;
      overload_restart_mode <= 1'b0;
      thr <= 1'b0;
      ext <= 1'b0;
      ton <= 1'b0;
    end else if (wr_i) begin
      // A host write wins over the wipe so a rewrite re-enables
      lvl <= lvl_wdata_i;
      pls <= pls_wdata_i;
      overload_restart_mode <= olr_wdata_i;
      thr <= thr_wdata_i;
      ext <= ext_wdata_i;
      ton <= ton_wdata_i;
    // Mode bits survive a recovery; only the level field is emptied
    end else if (lvl_wipe) begin
      lvl <= `SFP_LVL_RST;
    end
  end

  // internal 22 kHz carrier divider
  // Half period rounds down, so the carrier runs very slightly fast
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tdiv <= '0;
      carrier <= 1'b0;
    end else if (tdiv == TONE_LAST) begin
      tdiv <= '0;
      carrier <= ~carrier;
    end else begin
      tdiv <= tdiv + `SFP_TDIV_W'(1);
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tone <= 1'b0;
      power_en <= 1'b0;
      addr_sel <= 1'b0;
    end else begin
      tone <= next_tone;
      power_en <= next_power_en;
      addr_sel <= addr_sel_i;
    end
  end

  // sticky flags; read-clear only when cause inactive
  // flags reset low and rise only on a failure
  sfp_flag u_low (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .set_i(low_supply_i),
    .cause_i(low_supply_i),
    .read_i(rd_ok),
    .flag_o(supply_low_flag_o)
  );
  // overload flag, set at off entry or on clamp
  sfp_flag u_ol (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .set_i(ol_set),
    .cause_i(ol_cause),
    .read_i(rd_ok),
    .flag_o(overload_flag_o)
  );
  sfp_flag u_ot (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .set_i(overtemp_i),
    .cause_i(overtemp_i),
    .read_i(rd_ok),
    .flag_o(overtemp_flag_o)
  );

  // fault pin follows low-supply flag
  // Pin stays low until the flag is read clear, so a short dip is not missed
  assign fault_out_n_o = ~supply_low_flag_o;
  // Control bits back to the host
  assign output_level_select_o = lvl;
  assign pulsed_limit_select_o = pls;
  assign overload_restart_mode_o = overload_restart_mode;
  assign thermal_restart_mode_o = thr;
  assign external_tone_mode_o = ext;
  assign tone_on_o = ton;
  assign power_en_o = power_en;
  assign tone_o = tone;
  assign addr_sel_o = addr_sel;
endmodule

// ---- sfp_ctrl_checker.sv ----
// Assertion checker for the supply fault protection controller
`timescale 1ns/100ps
`include "sfp_defs.svh"
module sfp_ctrl_checker (
  input wire logic ref_clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic uvlo_i, // Lockout
  input wire logic low_supply_i, // Low supply
  input wire logic overload_i, // Overload
  input wire logic overtemp_i, // Hot
  input wire logic wr_i, // Write
  input wire logic [`SFP_LVL_W-1:0] lvl_wdata_i, // Level data
  input wire logic status_rd_i, // Read
  input wire logic addr_sel_i, // Address pin
  input wire logic [`SFP_LVL_W-1:0] output_level_select_o, // Level
  input wire logic pulsed_limit_select_o, // Clamp
  input wire logic supply_low_flag_o, // Low flag
  input wire logic overload_flag_o, // Load flag
  input wire logic overtemp_flag_o, // Hot flag
  input wire logic fault_out_n_o, // Fault pin
  input wire logic power_en_o, // Power
  input wire logic addr_sel_o, // Address
  input wire logic pls_wdata_i, // Clamp data
  input wire logic olr_wdata_i, // Load restart data
  input wire logic thr_wdata_i, // Hot restart data
  input wire logic ext_wdata_i, // External tone data
  input wire logic ton_wdata_i, // Tone on data
  input wire logic tone_gate_in_i, // Tone pin
  input wire logic overload_restart_mode_o, // Load restart
  input wire logic thermal_restart_mode_o, // Hot restart
  input wire logic external_tone_mode_o, // External tone
  input wire logic tone_on_o, // Tone on
  input wire logic tone_o // Tone out
);
  // One domain, one clock and reset for all
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  fault_pin_a: assert property (fault_out_n_o == !supply_low_flag_o)
    else $error("fault pin wrong");
  low_set_a: assert property (low_supply_i && !uvlo_i |=> supply_low_flag_o)
    else $error("low flag not set");
  low_hold_a: assert property (supply_low_flag_o && low_supply_i |=> supply_low_flag_o)
    else $error("low flag lost");
  hot_clear_a: assert property (overtemp_flag_o && status_rd_i && !overtemp_i && !uvlo_i
    |=> !overtemp_flag_o) else $error("hot flag not cleared");
  hot_cut_a: assert property (overtemp_i && !uvlo_i |=> !power_en_o && overtemp_flag_o)
    else $error("hot not cut");
  clamp_flag_a: assert property (pulsed_limit_select_o && overload_i && !uvlo_i
    |=> overload_flag_o) else $error("clamp flag missing");
  // Power must stay on for the first 8 cycles of the on window
  pulse_on_a: assert property ($rose(overload_i) && !pulsed_limit_select_o && power_en_o
    && !overtemp_i |=> (power_en_o && !overload_flag_o) [*8]) else $error("on window cut");
  lock_wipe_a: assert property (uvlo_i |=> output_level_select_o == 4'h0 && !power_en_o)
    else $error("lockout kept bits");
  addr_pin_a: assert property (1'b1 |=> addr_sel_o == $past(addr_sel_i))
    else $error("address not taken");
  write_load_a: assert property (wr_i && !uvlo_i |=> output_level_select_o == $past(lvl_wdata_i))
    else $error("level not loaded");
  mode_load_a: assert property (wr_i && !uvlo_i |=> {pulsed_limit_select_o,
    overload_restart_mode_o, thermal_restart_mode_o, external_tone_mode_o, tone_on_o} ==
    $past({pls_wdata_i, olr_wdata_i, thr_wdata_i, ext_wdata_i, ton_wdata_i}))
    else $error("mode bits not loaded");
  tone_ext_a: assert property (external_tone_mode_o && tone_on_o && power_en_o
    |=> tone_o == $past(tone_gate_in_i)) else $error("external tone not passed");
  tone_env_a: assert property (tone_on_o && !external_tone_mode_o && !tone_gate_in_i
    |=> !tone_o) else $error("envelope low but tone on");
  tone_off_a: assert property (!tone_on_o || !power_en_o |=> !tone_o)
    else $error("tone without enable");
endmodule
bind sfp_ctrl sfp_ctrl_checker i_chk (.ref_clk_i, .rst_i, .uvlo_i, .low_supply_i, .overload_i,
  .overtemp_i, .wr_i, .lvl_wdata_i, .status_rd_i, .addr_sel_i, .output_level_select_o,
  .pulsed_limit_select_o, .supply_low_flag_o, .overload_flag_o, .overtemp_flag_o,
  .fault_out_n_o, .power_en_o, .addr_sel_o, .pls_wdata_i, .olr_wdata_i, .thr_wdata_i,
  .ext_wdata_i, .ton_wdata_i, .tone_gate_in_i, .overload_restart_mode_o,
  .thermal_restart_mode_o, .external_tone_mode_o, .tone_on_o, .tone_o);

// ---- sfp_host_model.sv ----
// Host processor model: writes control bits, reads status, holds tone pin
`timescale 1ns/100ps
`include "sfp_defs.svh"
module sfp_host_model (
  input wire logic clk_i, // Clock
  output logic wr_o = 1'b0, // Write strobe
  output logic [`SFP_LVL_W-1:0] lvl_o = 4'h0, // Level
  output logic [4:0] bits_o = 5'h10, // Clamp, restarts, tone bits
  output logic rd_o = 1'b0, // Status read
  output logic gate_o = 1'b1 // Tone pin
);
  // One-cycle write of all bits, held after
  task automatic put(input logic [`SFP_LVL_W-1:0] l, input logic [4:0] m);
    @(posedge clk_i);
    wr_o <= 1'b1;
    {lvl_o, bits_o} <= {l, m};
    @(posedge clk_i);
    wr_o <= 1'b0;
  endtask
  // Tone pin idles high; one-cycle status read
  task automatic get();
    @(posedge clk_i);
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
  endtask
  // Tone pin level, changed just after an edge
  task automatic pin(input logic g);
    @(posedge clk_i);
    gate_o <= g;
  endtask
endmodule

// ---- sfp_ctrl_tb_top.sv ----
// Self-checking testbench for the supply fault protection controller
`timescale 1ns/100ps
`include "sfp_defs.svh"
module sfp_ctrl_tb_top;
  localparam int NON = 20; // Short on window
  localparam int NOFF = 50; // Short off window
  localparam int NTH = 4; // Short carrier half period
  logic ref_clk_i = 1'b0; // Clock
  logic rst_i = 1'b1; // Reset
  logic uv = 1'b0, low = 1'b0, ovl = 1'b0, hot = 1'b0, adr = 1'b0; // Causes
  logic wr, rd, gate, sl, of, overtemp_flag, fn, pe, tn; // Host lines and status
  logic [3:0] lvl, lvs, L; // Level in, out, chosen
  logic [4:0] bits; // Mode bits
  int n; // Tone-high cycles counted
  wire [9:0] obs = {tn, sl, of, overtemp_flag, fn, pe, lvs}; // Watched result
  logic [9:0] q[$]; // Noted results, oldest first
  int miscompares = 0;
  int cmp_count = 0;
  sfp_host_model i_host (.clk_i(ref_clk_i), .wr_o(wr), .lvl_o(lvl), .bits_o(bits),
    .rd_o(rd), .gate_o(gate));
  sfp_ctrl #(.ON_CYCLES(NON), .OFF_CYCLES(NOFF), .TONE_HALF(NTH)) i_dut (.ref_clk_i, .rst_i,
    .uvlo_i(uv),
    .low_supply_i(low), .overload_i(ovl), .overtemp_i(hot), .wr_i(wr), .lvl_wdata_i(lvl),
    .pls_wdata_i(bits[4]), .olr_wdata_i(bits[3]), .thr_wdata_i(bits[2]),
    .ext_wdata_i(bits[1]), .ton_wdata_i(bits[0]), .status_rd_i(rd), .tone_gate_in_i(gate),
    .addr_sel_i(adr), .output_level_select_o(lvs), .pulsed_limit_select_o(),
    .overload_restart_mode_o(), .thermal_restart_mode_o(), .external_tone_mode_o(),
    .tone_on_o(), .supply_low_flag_o(sl), .overload_flag_o(of), .overtemp_flag_o(overtemp_flag),
    .fault_out_n_o(fn), .power_en_o(pe), .tone_o(tn), .addr_sel_o());
  initial begin
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // Note a result, tone bit low unless given; compared at the next falling edge
  task automatic note(input logic [8:0] v, input logic t = 1'b0);
    q.push_back({t, v});
    @(posedge ref_clk_i);
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  always @(negedge ref_clk_i) begin
    if (q.size() > 0) begin
      chk(obs, q.pop_front());
    end
  end
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    wt(5000);
    miscompares++;
    summarize();
  end
  initial begin
    void'($urandom(32'h8baa));
    wt(3);
    rst_i <= 1'b0;
    wt(1);
    note(9'h020);
    L = 4'h1 + 4'($urandom % 15);
    adr <= 1'($urandom);
    i_host.put(L, 5'h00);
    wt(3);
    note({5'h03, L});
    low <= 1'b1;
    wt(3);
    note({5'h11, L});
    i_host.get();
    wt(2);
    note({5'h11, L});
    low <= 1'b0;
    i_host.get();
    wt(2);
    note({5'h03, L});
    $display("test low supply done");
    for (int m = 0; m < 2; m++) begin
      i_host.put(L, {2'b00, 1'(m), 2'b00});
      hot <= 1'b1;
      wt(3);
      note({5'h06, L});
      hot <= 1'b0;
      wt(3);
      note({4'h3, m == 0, m ? 4'h0 : L});
      i_host.get();
      wt(2);
      note({4'h1, m == 0, m ? 4'h0 : L});
      i_host.put(L, 5'h00);
    end
    $display("test overtemp done");
    for (int m = 0; m < 2; m++) begin
      i_host.put(L, {1'b0, 1'(m), 3'b000});
      ovl <= 1'b1;
      wt(5);
      note({5'h03, L});
      wt(NON + 2);
      note({5'h0A, L});
      wt(NOFF);
      note({5'h0B, L});
      ovl <= 1'b0;
      wt(20);
      note({5'h0A, L});
      wt(NOFF + NON + 10);
      note({4'h5, m == 0, m ? 4'h0 : L});
      i_host.get();
      wt(2);
      note({4'h1, m == 0, m ? 4'h0 : L});
      i_host.put(L, 5'h00);
    end
    $display("test pulsed overload done");
    i_host.put(L, 5'h10);
    ovl <= 1'b1;
    wt(NON + 5);
    note({5'h0B, L});
    ovl <= 1'b0;
    i_host.get();
    wt(2);
    note({5'h03, L});
    uv <= 1'b1;
    wt(3);
    note(9'h020);
    i_host.put(L, 5'h00);
    uv <= 1'b0;
    wt(3);
    note(9'h020);
    $display("test clamp and lockout done");
    i_host.put(L, 5'h03);
    wt(3);
    note({5'h03, L}, 1'b1);
    i_host.pin(1'b0);
    wt(2);
    note({5'h03, L});
    i_host.put(L, 5'h01);
    wt(2);
    note({5'h03, L});
    i_host.pin(1'b1);
    wt(2);
    // Any 16 cycles of a period-8 carrier hold exactly 8 high ones
    n = 0;
    repeat (16) begin
      @(negedge ref_clk_i);
      if (tn === 1'b1) begin
        n++;
      end
    end
    chk(10'(n), 10'h008);
    $display("test tone done");
    summarize();
  end
endmodule
